/* File: flash_pkg.sv */
// Shared constants, command codes, timing and types of the serial flash block
package flash_pkg;

  // Command codes taken from the first byte of a frame
  localparam logic [7:0] FAST_READ_OP = 8'h0b;  // Read with dummy byte
  localparam logic [7:0] PAGE_WRITE_OP = 8'h02; // page_write_cmd
  localparam logic [7:0] SECTOR_WIPE_OP = 8'hd8; // sector_wipe_cmd
  localparam logic [7:0] FULL_WIPE_OP = 8'hc7;  // full_array_wipe_cmd
  localparam logic [7:0] SLEEP_OP = 8'hb9;      // sleep_entry_cmd
  localparam logic [7:0] WAKE_OP = 8'hab;       // wake_and_signature_cmd
  localparam logic [7:0] UNLOCK_OP = 8'h06;     // write_unlock_cmd

  // Frame byte counts (saturating counter)
  localparam logic [2:0] NB_OPCODE = 3'h1;      // Opcode only
  localparam logic [2:0] NB_ADDR = 3'h4;        // Opcode plus address
  localparam logic [2:0] NB_SAT = 3'h5;         // Counter ceiling

  // Array geometry defaults
  localparam int ADDR_BITS = 21;                // A23..A21 are ignored
  localparam int SECTOR_BITS = 16;              // Bytes per sector, log2
  localparam logic [7:0] ERASED_BYTE = 8'hff;   // Erased value

  // Reset values
  localparam logic UNLOCK_RST = 1'b0;
  localparam logic BUSY_RST = 1'b0;
  localparam logic SLEEP_RST = 1'b0;
  localparam logic ACK_RST = 1'b1;              // Clears the frame flag
  localparam logic CS_N_RST = 1'b1;

  // Self-timed durations in ns, and cycle counts at the system clock
  localparam int CLK_PERIOD_NS = 4;
  localparam int PAGE_WRITE_TIME_NS = 2000;     // page_write_time
  localparam int SECTOR_WIPE_TIME_NS = 40000;   // sector_wipe_time
  localparam int FULL_WIPE_TIME_NS = 80000;     // full_wipe_time
  localparam int SLEEP_ENTRY_DELAY_NS = 3000;   // sleep_entry_delay
  localparam int PAGE_WRITE_CYC =
    (PAGE_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SECTOR_WIPE_CYC =
    (SECTOR_WIPE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FULL_WIPE_CYC =
    (FULL_WIPE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_ENTRY_CYC =
    (SLEEP_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Controller states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_PROG  = 6'h02,
    ST_SWIPE = 6'h04,
    ST_FWIPE = 6'h08,
    ST_DOZE  = 6'h10,
    ST_SLEEP = 6'h20
  } state_e;

  // Summary of one frame, held still by the link side after select rises
  typedef struct packed {
    logic [7:0]  op;
    logic [23:0] addr;
    logic [2:0]  nbytes;
    logic        aligned;
    logic        has_data;
  } frame_s;

endpackage

/* File: spi_flash_read_program_erase.sv */
// Serial flash device: link front end, frame decode, self-timed array cycles

module spi_flash_read_program_erase #(
  parameter int ADDR_W     = flash_pkg::ADDR_BITS,
  parameter int SECTOR_W   = flash_pkg::SECTOR_BITS,
  parameter int PROG_CYC   = flash_pkg::PAGE_WRITE_CYC,
  parameter int SWIPE_CYC  = flash_pkg::SECTOR_WIPE_CYC,
  parameter int FWIPE_CYC  = flash_pkg::FULL_WIPE_CYC,
  parameter int SLEEP_CYC  = flash_pkg::SLEEP_ENTRY_CYC
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       mosi,
  input  wire logic [2:0] protect_area_bits,
  output logic            miso,
  output logic            miso_oe,
  output logic            cycle_active_flag,
  output logic            write_unlock_latch,
  output logic            sleeping
);

  localparam int NSEC_W = ADDR_W - SECTOR_W;   // Sector index width

  // Storage shared by both domains; each array has one writing domain
  logic [7:0] mem [0:(1<<ADDR_W)-1];          // Array, written on clk
  logic [7:0] pbuf [0:255];                   // Page data, written on sclk
  logic [255:0] pmask_q;                      // Columns received this frame

  // Link side registers (sclk domain)
  logic              fresh_q;                 // First edge of a frame due
  logic [2:0]        bit_q;                   // Next bit slot in byte
  logic [2:0]        bytes_q;                 // Whole bytes, saturating
  logic [7:0]        shift_q;                 // Input shifter
  logic [7:0]        op_q;                    // Opcode of this frame
  logic [23:0]       addr_q;                  // Address bytes
  logic [7:0]        col_q;                   // Page column for writes
  logic              has_data_q;              // Program data seen
  logic              rd_en_q;                 // Read data phase active
  logic [ADDR_W-1:0] rd_addr_q;               // Next byte to fetch
  logic [7:0]        rd_byte_q;               // Byte being shifted out
  logic              started_q;               // Frame had clock edges
  logic              blk_s1_q;                // Busy/sleep sync, stage 1
  logic              blk_s2_q;                // Busy/sleep sync, stage 2
  logic              miso_q;                  // Falling-edge data
  logic              oe_q;                    // Falling-edge enable

  // Controller registers (clk domain)
  logic              cs_s1_q;
  logic              cs_s2_q;
  logic              cs_s3_q;
  logic              st_s1_q;
  logic              st_s2_q;
  logic              ack_q;                   // Clears started_q
  flash_pkg::state_e state_q;
  flash_pkg::state_e state_d;
  logic              wel_q;
  logic              busy_q;
  logic              sleep_q;
  logic              block_q;                 // Told to the link side
  logic [31:0]       wait_q;                  // Remaining cycle time
  logic [ADDR_W-1:0] walk_q;                  // Array walk position
  logic              walk_done_q;
  logic [ADDR_W-1:0] base_q;                  // Target address

  // Sector lies in the protected top area; span doubles per step of bp
  function automatic logic is_prot(input logic [ADDR_W-1:0] a,
                                   input logic [2:0] bp);
    logic [NSEC_W-1:0] from_top;
    from_top = ~a[ADDR_W-1:SECTOR_W];
    is_prot = (bp != 3'h0) && ((from_top >> (bp - 3'h1)) == '0);
  endfunction

  // Link side decode
  wire [7:0] rx_byte = {shift_q[6:0], mosi};
  wire [2:0] bit_cur = fresh_q ? 3'h0 : bit_q;
  wire [2:0] bytes_cur = fresh_q ? 3'h0 : bytes_q;
  wire       byte_done = bit_cur == 3'h7;
  wire [2:0] bytes_nx = (byte_done && bytes_cur != flash_pkg::NB_SAT)
                        ? bytes_cur + 3'h1 : bytes_cur;
  wire       in_addr = bytes_cur != 3'h0 && bytes_cur < flash_pkg::NB_ADDR;
  wire       data_byte = byte_done && bytes_cur >= flash_pkg::NB_ADDR;
  wire       pbuf_we = data_byte && !blk_s2_q
                       && op_q == flash_pkg::PAGE_WRITE_OP;
  wire       rd_start = byte_done && bytes_cur == flash_pkg::NB_ADDR
                        && op_q == flash_pkg::FAST_READ_OP && !blk_s2_q;
  wire       rd_next = rd_start || (byte_done && rd_en_q);

  // Select high arms a restart so counters need no edge outside a frame
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
      fresh_q <= 1'b1;
    else
      fresh_q <= 1'b0;
  end

  // Frame-seen flag, cleared by the controller once it has used a frame
  always_ff @(posedge sclk or posedge ack_q)
  begin
    if (ack_q)
      started_q <= 1'b0;
    else
      started_q <= 1'b1;
  end

  // Input shifting and byte counting on the rising edge
  always_ff @(posedge sclk)
  begin
    bit_q   <= bit_cur + 3'h1;
    shift_q <= rx_byte;
    bytes_q <= bytes_nx;
  end

  // Opcode and address capture; high address byte kept whole, trimmed later
  always_ff @(posedge sclk)
  begin
    if (byte_done && bytes_cur == 3'h0)
      op_q <= rx_byte;
    if (byte_done && in_addr)
      addr_q <= {addr_q[15:0], rx_byte};
  end

  // Page buffer fill; column wraps in the page so later bytes overwrite
  always_ff @(posedge sclk)
  begin
    if (byte_done && bytes_cur == 3'h3)
      col_q <= rx_byte;
    else if (pbuf_we)
      col_q <= col_q + 8'h01;
    if (pbuf_we)
      pbuf[col_q] <= rx_byte;
  end

  // Received-column mask; restarts at the first data byte, not at select,
  // so a frame arriving during a program walk cannot wipe the live mask
  always_ff @(posedge sclk)
  begin
    if (pbuf_we && !has_data_q)
      pmask_q <= 256'h1 << col_q;
    else if (pbuf_we)
      pmask_q[col_q] <= 1'b1;
    if (fresh_q)
      has_data_q <= 1'b0;
    else if (pbuf_we)
      has_data_q <= 1'b1;
  end

  // Read fetch: next byte is loaded as the previous one completes
  always_ff @(posedge sclk)
  begin
    if (fresh_q)
      rd_en_q <= 1'b0;
    else if (rd_start)
      rd_en_q <= 1'b1;
    if (byte_done && bytes_cur == 3'h3)
      rd_addr_q <= {addr_q[ADDR_W-9:0], rx_byte};
    else if (rd_next)
      rd_addr_q <= rd_addr_q + ADDR_W'(1);
    if (rd_next)
      rd_byte_q <= mem[rd_addr_q];
  end

  // Busy or sleeping, brought over from the controller
  always_ff @(posedge sclk)
  begin
    blk_s1_q <= block_q;
    blk_s2_q <= blk_s1_q;
  end

  // Output on the falling edge; deselect drops the drive at once
  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      miso_q <= 1'b0;
      oe_q   <= 1'b0;
    end
    else
    begin
      miso_q <= rd_byte_q[~bit_q];
      oe_q   <= rd_en_q;
    end
  end

  assign miso    = miso_q;
  assign miso_oe = oe_q;

  // Frame summary; held still from the last clock edge until the next frame
  flash_pkg::frame_s fr;
  assign fr = {op_q, addr_q, bytes_q, bit_q == 3'h0, has_data_q};

  // Controller decode; frame fields are read only at the deselect edge
  wire cs_rise = cs_s2_q && !cs_s3_q;
  wire go = cs_rise && st_s2_q;
  wire idle_st = state_q == flash_pkg::ST_IDLE;
  wire asleep = state_q == flash_pkg::ST_SLEEP
                || state_q == flash_pkg::ST_DOZE;
  wire op_only = fr.nbytes == flash_pkg::NB_OPCODE && fr.aligned;
  wire [ADDR_W-1:0] tgt = fr.addr[ADDR_W-1:0];
  wire prot = is_prot(tgt, protect_area_bits);
  wire wr_ok = go && idle_st && wel_q;
  wire do_write_unlock_cmd = go && idle_st && fr.op == flash_pkg::UNLOCK_OP && op_only;
  wire do_pp = wr_ok && fr.op == flash_pkg::PAGE_WRITE_OP
               && fr.has_data && fr.aligned && !prot;
  wire do_se = wr_ok && fr.op == flash_pkg::SECTOR_WIPE_OP && !prot
               && fr.nbytes == flash_pkg::NB_ADDR && fr.aligned;
  wire do_be = wr_ok && fr.op == flash_pkg::FULL_WIPE_OP && op_only
               && protect_area_bits == 3'h0;
  wire do_dp = go && idle_st && fr.op == flash_pkg::SLEEP_OP && op_only;
  wire do_wake = go && asleep && fr.op == flash_pkg::WAKE_OP
                 && fr.nbytes != 3'h0;
  wire do_start = do_pp || do_se || do_be;
  wire busy_st = state_q == flash_pkg::ST_PROG
                 || state_q == flash_pkg::ST_SWIPE
                 || state_q == flash_pkg::ST_FWIPE;

  // Array walk addressing and data
  wire in_prog = state_q == flash_pkg::ST_PROG;
  wire in_swipe = state_q == flash_pkg::ST_SWIPE;
  wire walk_last = in_prog ? &walk_q[7:0]
                   : in_swipe ? &walk_q[SECTOR_W-1:0] : &walk_q;
  wire [ADDR_W-1:0] mem_a = in_prog ? {base_q[ADDR_W-1:8], walk_q[7:0]}
                   : in_swipe ? {base_q[ADDR_W-1:SECTOR_W],
                                 walk_q[SECTOR_W-1:0]} : walk_q;
  wire [7:0] mem_d = in_prog ? (mem[mem_a] & pbuf[walk_q[7:0]])
                     : flash_pkg::ERASED_BYTE;
  wire mem_we = busy_st && !walk_done_q
                && (!in_prog || pmask_q[walk_q[7:0]]);
  wire cyc_end = walk_done_q && wait_q == 32'h0;
  wire [31:0] load_cyc = do_pp ? 32'(PROG_CYC - 1)
                       : do_se ? 32'(SWIPE_CYC - 1)
                       : do_be ? 32'(FWIPE_CYC - 1) : 32'(SLEEP_CYC - 1);

  // Next state
  always_comb
  begin
    case (state_q)
      flash_pkg::ST_IDLE:
      begin
        if (do_pp)
          state_d = flash_pkg::ST_PROG;
        else if (do_se)
          state_d = flash_pkg::ST_SWIPE;
        else if (do_be)
          state_d = flash_pkg::ST_FWIPE;
        else if (do_dp)
          state_d = flash_pkg::ST_DOZE;
        else
          state_d = flash_pkg::ST_IDLE;
      end
      flash_pkg::ST_PROG, flash_pkg::ST_SWIPE, flash_pkg::ST_FWIPE:
        state_d = cyc_end ? flash_pkg::ST_IDLE : state_q;
      flash_pkg::ST_DOZE:
      begin
        if (do_wake)
          state_d = flash_pkg::ST_IDLE;
        else if (wait_q == 32'h0)
          state_d = flash_pkg::ST_SLEEP;
        else
          state_d = flash_pkg::ST_DOZE;
      end
      flash_pkg::ST_SLEEP:
        state_d = do_wake ? flash_pkg::ST_IDLE : flash_pkg::ST_SLEEP;
      default:
        state_d = flash_pkg::ST_IDLE;
    endcase
  end

  // Select and frame-flag synchronisers, plus the frame-flag clear
  always_ff @(posedge clk)
  begin
    cs_s1_q <= cs_n;
    cs_s2_q <= cs_s1_q;
    st_s1_q <= started_q;
    st_s2_q <= st_s1_q;
    if (reset)
    begin
      cs_s3_q <= flash_pkg::CS_N_RST;
      ack_q   <= flash_pkg::ACK_RST;
    end
    else
    begin
      cs_s3_q <= cs_s2_q;
      if (cs_rise)
        ack_q <= 1'b1;
      else if (!st_s2_q)
        ack_q <= 1'b0;
    end
  end

  // State and status flags; reset is power-up standby
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= flash_pkg::ST_IDLE;
      wel_q   <= flash_pkg::UNLOCK_RST;
      busy_q  <= flash_pkg::BUSY_RST;
      sleep_q <= flash_pkg::SLEEP_RST;
      block_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      busy_q  <= state_d == flash_pkg::ST_PROG
                 || state_d == flash_pkg::ST_SWIPE
                 || state_d == flash_pkg::ST_FWIPE;
      sleep_q <= state_d == flash_pkg::ST_SLEEP;
      block_q <= state_d != flash_pkg::ST_IDLE;
      if (do_write_unlock_cmd)
        wel_q <= 1'b1;
      else if (do_start)
        wel_q <= 1'b0;
    end
  end

  // Cycle timer and array walk
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wait_q      <= 32'h0;
      walk_q      <= '0;
      walk_done_q <= 1'b1;
      base_q      <= '0;
    end
    else if (do_start || do_dp)
    begin
      wait_q      <= load_cyc;
      walk_q      <= '0;
      walk_done_q <= do_dp;
      base_q      <= tgt;
    end
    else
    begin
      if (wait_q != 32'h0)
        wait_q <= wait_q - 32'h1;
      if (busy_st && !walk_done_q)
      begin
        walk_q      <= walk_q + ADDR_W'(1);
        walk_done_q <= walk_last;
      end
    end
  end

  // Array write; program ANDs so bits only fall, erases write ones
  always_ff @(posedge clk)
  begin
    if (mem_we)
      mem[mem_a] <= mem_d;
  end

  assign cycle_active_flag  = busy_q;
  assign write_unlock_latch = wel_q;
  assign sleeping           = sleep_q;

  // Checks on the controller and the link-side read start
  sequence sleep_taken;
    do_dp;
  endsequence

  sequence cycle_begins;
    $rose(busy_q);
  endsequence

  start_needs_wel_a: assert property (
    @(posedge clk) disable iff (reset)
    cycle_begins |-> $past(wel_q) && $past(cs_rise) && !wel_q)
    else $error("cycle began without unlock latch");

  bulk_guard_a: assert property (
    @(posedge clk) disable iff (reset)
    $rose(busy_q) && state_q == flash_pkg::ST_FWIPE
    |-> $past(protect_area_bits) == 3'h0)
    else $error("bulk erase ran with protection set");

  prot_guard_a: assert property (
    @(posedge clk) disable iff (reset)
    go && prot && state_q == flash_pkg::ST_IDLE |=> !busy_q)
    else $error("protected area cycle started");

  sleep_delay_a: assert property (
    @(posedge clk) disable iff (reset)
    sleep_taken |=> (!sleep_q && !busy_q)[*8])
    else $error("sleep entered before its delay");

  discard_keep_a: assert property (
    @(posedge clk) disable iff (reset)
    go && idle_st && !do_write_unlock_cmd && !do_start && !do_dp
    |=> $stable(wel_q) && !busy_q && !sleep_q)
    else $error("discarded command changed state");

  sleep_refuse_a: assert property (
    @(posedge clk) disable iff (reset)
    sleep_q && go |=> !busy_q ##1 !busy_q)
    else $error("write accepted while asleep");

  cycle_end_a: assert property (
    @(posedge clk) disable iff (reset)
    $fell(busy_q) |-> $past(wait_q) == 32'h0 && $past(walk_done_q))
    else $error("busy flag fell before cycle time");

  read_reject_a: assert property (
    @(posedge sclk) disable iff (cs_n)
    $rose(rd_en_q) |-> $past(!blk_s2_q) && $past(op_q) == flash_pkg::FAST_READ_OP)
    else $error("read started while busy");

endmodule

/* File: spi_flash_read_program_erase_bench.sv */
// Testbench of the serial flash block: command frames against a byte model
module spi_flash_read_program_erase_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AW = 12;          // Short array for simulation
  localparam int SZ = 1 << AW;     // Array bytes
  logic       clk;                 // System clock
  logic       reset;               // Synchronous reset
  logic [2:0] protect_area_bits;   // Protection setting
  wire logic  sclk;                // Link clock from the host
  wire logic  cs_n;                // Select from the host
  wire logic  mosi;                // Data to the device
  wire logic  miso;                // Data from the device
  wire logic  miso_oe;             // Device output enable
  wire logic  cycle_active_flag;   // Busy
  wire logic  write_unlock_latch;  // Write latch
  wire logic  sleeping;            // Deep power-down reached
  logic [7:0] mem_exp [0:SZ-1];    // Expected array contents
  int         err_count;           // Mismatches
  int         check_count;         // Comparisons made

  spi_flash_read_program_erase #(.ADDR_W(AW), .SECTOR_W(8), .SWIPE_CYC(50),
    .FWIPE_CYC(100), .SLEEP_CYC(20)) DUT (.clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n),
    .mosi(mosi), .protect_area_bits(protect_area_bits), .miso(miso), .miso_oe(miso_oe),
    .cycle_active_flag(cycle_active_flag), .write_unlock_latch(write_unlock_latch),
    .sleeping(sleeping));

  spi_host_model host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe));

  // 250 MHz system clock
  initial clk = 1'b0;
  always #2 clk = ~clk;

  // Compare one value, counting every call
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    check_count++;
    if (seen !== want)
    begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  // Verdict and end of run, also reached by the watchdog
  task automatic print_verdict();
    if (err_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Data byte k of a program frame
  function automatic logic [7:0] dat(input logic [7:0] seed, input int k);
    return seed + k[7:0] * 8'h1d;
  endfunction

  // One frame: opcode, optional address, nd bytes, extra bits of a spare byte
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input bit na, input int nd,
                       input logic [7:0] seed, input int extra, input int nrx);
    int k;
    host.tx.delete();
    host.tx.push_back(op);
    if (na)
    begin
      host.tx.push_back(a[23:16]);
      host.tx.push_back(a[15:8]);
      host.tx.push_back(a[7:0]);
    end
    for (k = 0; k < nd; k++)
      host.tx.push_back(dat(seed, k));
    if (extra > 0)
      host.tx.push_back(8'ha5);
    host.xfer(8 * (host.tx.size() - (extra > 0)) + extra, nrx);
  endtask

  // Flag levels: busy, latch, sleeping
  task automatic flags(input logic b, input logic l, input logic s);
    chk({5'h00, cycle_active_flag, write_unlock_latch, sleeping}, {5'h00, b, l, s});
  endtask

  // Unlock, then a program the model expects to run; only the last page of bytes lands
  task automatic prog(input logic [23:0] a, input int nd, input logic [7:0] seed);
    int k;
    frame(flash_pkg::UNLOCK_OP, 24'h000000, 0, 0, 8'h00, 0, 0);
    frame(flash_pkg::PAGE_WRITE_OP, a, 1, nd, seed, 0, 0);
    flags(1'b1, 1'b0, 1'b0);
    for (k = (nd > 256) ? nd - 256 : 0; k < nd; k++)
      mem_exp[{a[AW-1:8], a[7:0] + k[7:0]}] &= dat(seed, k);
  endtask

  // Wait for the self-timed cycle to end, bounded above the 4096-byte bulk walk
  task automatic wait_idle();
    int n;
    n = 0;
    while (cycle_active_flag !== 1'b0 && n < 8000)
    begin
      @(negedge clk);
      n++;
    end
    chk(n < 8000, 1'b1);
  endtask

  // Fast read of n bytes against the model
  task automatic rd(input logic [23:0] a, input int n);
    int k;
    frame(flash_pkg::FAST_READ_OP, a, 1, 1, 8'h00, 0, n);
    for (k = 0; k < n; k++)
      chk(host.rx[k], mem_exp[(a[AW-1:0] + k) % SZ]);
    chk(host.oe_seen == 8 * n, 1'b1);
    chk(miso_oe, 1'b0);
  endtask

  // Hang guard, well beyond the expected run
  initial
  begin
    #300000;
    err_count++;
    print_verdict();
  end

  // Main sequence
  initial
  begin
    err_count = 0;
    check_count = 0;
    reset = 1'b1;
    protect_area_bits = 3'h0;
    repeat (16) @(negedge clk);
    reset = 1'b0;
    repeat (12) @(negedge clk);
    flags(1'b0, 1'b0, 1'b0);
    // Erase refused while locked, then an opcode with a trailing partial byte refused
    frame(flash_pkg::FULL_WIPE_OP, 24'h000000, 0, 0, 8'h00, 0, 0);
    flags(1'b0, 1'b0, 1'b0);
    frame(flash_pkg::UNLOCK_OP, 24'h000000, 0, 0, 8'h00, 0, 0);
    flags(1'b0, 1'b1, 1'b0);
    frame(flash_pkg::FULL_WIPE_OP, 24'h000000, 0, 0, 8'h00, 3, 0);
    flags(1'b0, 1'b1, 1'b0);
    frame(flash_pkg::FULL_WIPE_OP, 24'h000000, 0, 0, 8'h00, 0, 0);
    flags(1'b1, 1'b0, 1'b0);
    wait_idle();
    for (int i = 0; i < SZ; i++)
      mem_exp[i] = flash_pkg::ERASED_BYTE;
    // In-page wrap, overlong page, repeated program that may only clear bits
    prog(24'he000f0, 20, 8'h30);
    wait_idle();
    prog(24'h000100, 260, 8'h11);
    wait_idle();
    prog(24'h000000, 4, 8'hff);
    wait_idle();
    rd(24'hf000ec, 24);
    rd(24'h0001fc, 8);
    rd(24'hfffffe, 4);
    // Discarded writes: partial byte, protected page and sector, bulk with protection
    frame(flash_pkg::UNLOCK_OP, 24'h000000, 0, 0, 8'h00, 0, 0);
    frame(flash_pkg::PAGE_WRITE_OP, 24'h000010, 1, 3, 8'h00, 5, 0);
    flags(1'b0, 1'b1, 1'b0);
    @(negedge clk) protect_area_bits = 3'h1;
    frame(flash_pkg::PAGE_WRITE_OP, 24'h000f20, 1, 2, 8'h00, 0, 0);
    flags(1'b0, 1'b1, 1'b0);
    frame(flash_pkg::SECTOR_WIPE_OP, 24'h000f80, 1, 0, 8'h00, 0, 0);
    flags(1'b0, 1'b1, 1'b0);
    frame(flash_pkg::FULL_WIPE_OP, 24'h000000, 0, 0, 8'h00, 0, 0);
    flags(1'b0, 1'b1, 1'b0);
    @(negedge clk) protect_area_bits = 3'h0;
    // Sector erase: trailing byte discards it, then any address in the sector
    frame(flash_pkg::SECTOR_WIPE_OP, 24'h0001a3, 1, 1, 8'h00, 0, 0);
    flags(1'b0, 1'b1, 1'b0);
    frame(flash_pkg::SECTOR_WIPE_OP, 24'h0001a3, 1, 0, 8'h00, 0, 0);
    flags(1'b1, 1'b0, 1'b0);
    wait_idle();
    for (int i = 16'h100; i < 16'h200; i++)
      mem_exp[i] = flash_pkg::ERASED_BYTE;
    rd(24'h0001fc, 8);
    // Sleep refused while a program runs
    prog(24'h000300, 8, 8'h42);
    frame(flash_pkg::SLEEP_OP, 24'h000000, 0, 0, 8'h00, 0, 0);
    wait_idle();
    repeat (40) @(negedge clk);
    flags(1'b0, 1'b0, 1'b0);
    rd(24'h000300, 8);
    // Sleep: opcode with a trailing partial byte refused, then entry, locked out, wake
    frame(flash_pkg::SLEEP_OP, 24'h000000, 0, 0, 8'h00, 2, 0);
    repeat (40) @(negedge clk);
    flags(1'b0, 1'b0, 1'b0);
    frame(flash_pkg::SLEEP_OP, 24'h000000, 0, 0, 8'h00, 0, 0);
    repeat (30) @(negedge clk);
    flags(1'b0, 1'b0, 1'b1);
    frame(flash_pkg::UNLOCK_OP, 24'h000000, 0, 0, 8'h00, 0, 0);
    flags(1'b0, 1'b0, 1'b1);
    frame(flash_pkg::FAST_READ_OP, 24'h000000, 1, 1, 8'h00, 0, 1);
    chk(host.oe_seen == 0, 1'b1);
    frame(flash_pkg::WAKE_OP, 24'h000000, 0, 0, 8'h00, 0, 0);
    flags(1'b0, 1'b0, 1'b0);
    frame(flash_pkg::UNLOCK_OP, 24'h000000, 0, 0, 8'h00, 0, 0);
    flags(1'b0, 1'b1, 1'b0);
    print_verdict();
  end
endmodule

/* File: spi_host_model.sv */
// SPI host model: drives select, link clock and serial data, captures read data
module spi_host_model (
  output logic      sclk,    // Link clock, idles low
  output logic      cs_n,    // Select, active low
  output logic      mosi,    // Serial data to the device
  input  wire logic miso,    // Serial data from the device
  input  wire logic miso_oe  // High while the device drives
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 24;  // Half of the 48 ns link period
  logic [7:0] tx[$];         // Bytes to send, MSB first
  logic [7:0] rx[$];         // Bytes captured after the sent bits
  int         oe_seen;       // Read samples taken while the device drove

  // Idle link: deselected, clock low
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    oe_seen = 0;
  end

  // One frame; the clock runs only while selected, and select rises
  // after exactly nbits plus eight per read byte, so a partial byte is always deliberate
  task automatic xfer(input int nbits, input int nrx);
    logic [7:0] b;
    int         i;
    rx.delete();
    oe_seen = 0;
    b = 8'h00;
    #7 cs_n = 1'b0;                // Odd offset keeps the link unrelated in phase
    for (i = 0; i < nbits; i++)
    begin
      mosi = tx[i / 8][7 - i % 8];
      #HALF sclk = 1'b1;
      #HALF sclk = 1'b0;
    end
    for (i = 0; i < 8 * nrx; i++)
    begin
      mosi = ~mosi;                // Don't-care input that never holds still
      #HALF sclk = 1'b1;
      b = {b[6:0], miso};          // Sampled a half period after it changed
      oe_seen += (miso_oe === 1'b1);
      #HALF sclk = 1'b0;
      if (i % 8 == 7)
        rx.push_back(b);
    end
    #HALF cs_n = 1'b1;
    mosi = ~mosi;                  // A released line shows no stale value
    #60;                           // Idle gap; also covers the flag latency
  endtask
endmodule
